// file: ccp_ctrl.sv
// Control and status pin logic of the multi-loop clock generator
`timescale 1ns/1ps

module ccp_ctrl
	import ccp_pkg::*;
#(
	parameter int N  = CCP_NUM_OUTS,
	parameter int SW = CCP_STEP_W
)(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            host_if_sel,
	input  wire logic            spi_four_wire,
	input  wire logic            sdio_in,
	output logic                 sdio_out,
	output logic                 sdio_oe,
	input  wire logic            addr_high_or_serial_out_in,
	output logic                 addr_high_or_serial_out_out,
	output logic                 addr_high_or_serial_out_oe,
	input  wire logic            addr_low_or_chip_select_n,
	input  wire logic            sclk,
	input  wire logic            i2c_sda_low,
	input  wire logic            spi_tx_bit,
	input  wire logic            spi_tx_en,
	output logic                 port_is_i2c,
	output logic                 port_is_spi4,
	output logic [1:0]           i2c_addr_sel,
	output logic                 spi_selected,
	output logic                 serial_data_in,
	output logic                 serial_clk_rise,
	input  wire logic            status_irq_clear,
	output logic                 status_change_irq_n,
	output logic                 status_change_irq_n_oe,
	input  wire logic [3:0]      loop_lock_raw,
	input  wire logic            ref_loss_raw,
	output logic                 loop_a_lock_ok,
	output logic                 loop_b_lock_ok,
	output logic                 loop_c_lock_ok,
	output logic                 loop_d_lock_ok,
	output logic                 ref_signal_lost,
	output logic                 ref_ext_mode,
	input  wire logic            out_enable_pin_first_n,
	input  wire logic            out_enable_pin_second_n,
	input  wire logic            cfg_load,
	input  wire logic [N-1:0]    cfg_first_map,
	input  wire logic [N-1:0]    cfg_second_map,
	input  wire logic [N-1:0]    cfg_reg_en,
	input  wire logic [N-1:0]    cfg_sync_dis,
	input  wire logic [2*N-1:0]  cfg_dis_state,
	input  wire logic            cfg_los_keep,
	input  wire logic            cfg_ref_ext,
	input  wire logic [SW-1:0]   cfg_step_size,
	input  wire logic            loop_select_bit0,
	input  wire logic            loop_select_bit1,
	input  wire logic            freq_step_up,
	input  wire logic            freq_step_down,
	output logic [3:0]           step_pulse,
	output logic                 step_down,
	output logic [4*SW-1:0]      loop_freq_offset,
	input  wire logic [N-1:0]    out_src,
	output logic [N-1:0]         out_clk,
	output logic [N-1:0]         out_clk_oe
);
	typedef struct packed {
		logic [N-1:0]    first_map;
		logic [N-1:0]    second_map;
		logic [N-1:0]    reg_en;
		logic [N-1:0]    sync_dis;
		logic [2*N-1:0]  dis_state;
		logic            los_keep;
		logic            ref_ext;
		logic [SW-1:0]   step_size;
		logic            run;
		logic [N-1:0]    en_req;
		logic [3:0]      lock_ok;
		logic            los;
		logic            irq_pend;
		logic            irq_n;
		logic            up_prev;
		logic            dn_prev;
		logic [3:0]      step_pulse;
		logic            step_down;
		logic [4*SW-1:0] offset;
		logic            is_i2c;
		logic            is_spi4;
		logic [1:0]      i2c_addr;
		logic            spi_sel;
		logic            ser_in;
		logic            sclk_prev;
		logic            sclk_rise;
		logic            sdio_out;
		logic            sdio_oe;
		logic            ahi_out;
		logic            ahi_oe;
	} ccp_ctrl_state_t;

	ccp_ctrl_state_t cur_r;
	ccp_ctrl_state_t cur_nxt;

	logic [CCP_SYNC_W-1:0] sync_q;
	logic                  if_sel_s;
	logic                  alo_s;
	logic                  ahi_s;
	logic                  sdio_s;
	logic                  sclk_s;
	logic                  los_s;
	logic [3:0]            lock_s;
	logic                  oe1_n_s;
	logic                  oe2_n_s;
	logic [1:0]            sel_s;
	logic                  up_s;
	logic                  dn_s;
	logic                  up_e;
	logic                  dn_e;
	logic                  stat_chg;

	////////////////////////////////////////////////////////////////////////
	// All pins and the serial clock cross into clk here
	ccp_pin_sync #(.W(CCP_SYNC_W)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({host_if_sel, addr_low_or_chip_select_n,
			addr_high_or_serial_out_in, sdio_in, sclk, ref_loss_raw,
			loop_lock_raw, out_enable_pin_first_n,
			out_enable_pin_second_n, loop_select_bit1, loop_select_bit0,
			freq_step_up, freq_step_down}),
		.q     (sync_q)
	);

	assign {if_sel_s, alo_s, ahi_s, sdio_s, sclk_s, los_s, lock_s,
		oe1_n_s, oe2_n_s, sel_s, up_s, dn_s} = sync_q;
	assign up_e     = up_s & ~cur_r.up_prev;
	assign dn_e     = dn_s & ~cur_r.dn_prev;
	assign stat_chg = (lock_s != cur_r.lock_ok) | (los_s != cur_r.los);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic i2c;
		logic spi4;
		i2c  = (if_sel_s == CCP_IF_SEL_I2C);
		spi4 = !i2c && spi_four_wire;
		cur_nxt = cur_r;
		if (cfg_load)
		begin
			cur_nxt.first_map  = cfg_first_map;
			cur_nxt.second_map = cfg_second_map;
			cur_nxt.reg_en     = cfg_reg_en;
			cur_nxt.sync_dis   = cfg_sync_dis;
			cur_nxt.dis_state  = cfg_dis_state;
			cur_nxt.los_keep   = cfg_los_keep;
			cur_nxt.ref_ext    = cfg_ref_ext;
			cur_nxt.step_size  = cfg_step_size;
		end
		cur_nxt.run = 1'b1;
		// Pins high disable; software can only narrow what pins allow
		for (int i = 0; i < N; i++)
			cur_nxt.en_req[i] = cur_r.run && cur_r.reg_en[i]
				&& !(cur_r.first_map[i] && oe1_n_s)
				&& !(cur_r.second_map[i] && oe2_n_s)
				&& !(los_s && !cur_r.los_keep);
		cur_nxt.lock_ok  = lock_s;
		cur_nxt.los      = los_s;
		// A change in the clear cycle still leaves the flag set
		cur_nxt.irq_pend = stat_chg
			|| (cur_r.irq_pend && !status_irq_clear);
		cur_nxt.irq_n    = !cur_nxt.irq_pend;
		cur_nxt.up_prev    = up_s;
		cur_nxt.dn_prev    = dn_s;
		cur_nxt.step_pulse = 4'h0;
		if (up_e ^ dn_e)
		begin
			cur_nxt.step_pulse = ccp_loop_onehot(sel_s);
			cur_nxt.step_down  = dn_e;
			if (dn_e)
				cur_nxt.offset[sel_s*SW +: SW] =
					cur_r.offset[sel_s*SW +: SW] - cur_r.step_size;
			else
				cur_nxt.offset[sel_s*SW +: SW] =
					cur_r.offset[sel_s*SW +: SW] + cur_r.step_size;
		end
		cur_nxt.is_i2c    = i2c;
		cur_nxt.is_spi4   = spi4;
		cur_nxt.i2c_addr  = i2c ? {ahi_s, alo_s} : 2'h0;
		cur_nxt.spi_sel   = !i2c && !alo_s;
		cur_nxt.ser_in    = sdio_s;
		cur_nxt.sclk_prev = sclk_s;
		cur_nxt.sclk_rise = sclk_s && !cur_r.sclk_prev;
		cur_nxt.ahi_out   = spi_tx_bit;
		cur_nxt.ahi_oe    = spi4 && spi_tx_en && cur_nxt.spi_sel;
		if (i2c)
		begin
			cur_nxt.sdio_out = 1'b0;
			cur_nxt.sdio_oe  = i2c_sda_low;
		end
		else if (!spi4)
		begin
			cur_nxt.sdio_out = spi_tx_bit;
			cur_nxt.sdio_oe  = spi_tx_en && cur_nxt.spi_sel;
		end
		else
		begin
			cur_nxt.sdio_out = 1'b0;
			cur_nxt.sdio_oe  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_r            <= '0;
			cur_r.irq_n      <= 1'b1;
			cur_r.first_map  <= {N{CCP_RST_FIRST_MAP}};
			cur_r.second_map <= {N{CCP_RST_SECOND_MAP}};
			cur_r.reg_en     <= {N{CCP_RST_REG_EN}};
			cur_r.sync_dis   <= {N{CCP_RST_SYNC_DIS}};
			cur_r.los_keep   <= CCP_RST_LOS_KEEP;
			cur_r.ref_ext    <= CCP_RST_REF_EXT;
			cur_r.step_size  <= SW'(CCP_RST_STEP);
		end
		else
			cur_r <= cur_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	ccp_gate_if gif [N] ();

	generate
		for (genvar gi = 0; gi < N; gi++)
		begin : g_out
			assign gif[gi].en_req    = cur_r.en_req[gi];
			assign gif[gi].sync_mode = cur_r.sync_dis[gi];
			assign gif[gi].dis_state =
				ccp_dis_t'(cur_r.dis_state[gi*CCP_DIS_W +: CCP_DIS_W]);
			assign gif[gi].src       = out_src[gi];
			assign out_clk[gi]       = gif[gi].pin;
			assign out_clk_oe[gi]    = gif[gi].pin_oe;
			ccp_out_gate u_gate (
				.clk   (clk),
				.rst_n (rst_n),
				.g     (gif[gi])
			);
		end
	endgenerate

	assign sdio_out                    = cur_r.sdio_out;
	assign sdio_oe                     = cur_r.sdio_oe;
	assign addr_high_or_serial_out_out = cur_r.ahi_out;
	assign addr_high_or_serial_out_oe  = cur_r.ahi_oe;
	assign port_is_i2c                 = cur_r.is_i2c;
	assign port_is_spi4                = cur_r.is_spi4;
	assign i2c_addr_sel                = cur_r.i2c_addr;
	assign spi_selected                = cur_r.spi_sel;
	assign serial_data_in              = cur_r.ser_in;
	assign serial_clk_rise             = cur_r.sclk_rise;
	assign status_change_irq_n         = cur_r.irq_n;
	assign status_change_irq_n_oe      = cur_r.irq_pend;
	assign loop_a_lock_ok              = cur_r.lock_ok[CCP_LOOP_A];
	assign loop_b_lock_ok              = cur_r.lock_ok[CCP_LOOP_B];
	assign loop_c_lock_ok              = cur_r.lock_ok[CCP_LOOP_C];
	assign loop_d_lock_ok              = cur_r.lock_ok[CCP_LOOP_D];
	assign ref_signal_lost             = cur_r.los;
	assign ref_ext_mode                = cur_r.ref_ext;
	assign step_pulse                  = cur_r.step_pulse;
	assign step_down                   = cur_r.step_down;
	assign loop_freq_offset            = cur_r.offset;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence up_only_s;
		up_e && !dn_e;
	endsequence

	if_mode_a: assert property (
		if_sel_s |=> port_is_i2c)
		else $error("high select did not pick the two-wire port");
	spi4_in_a: assert property (
		port_is_spi4 |-> !sdio_oe)
		else $error("data pin driven in 4-wire mode");
	i2c_addr_a: assert property (
		port_is_i2c |-> !addr_high_or_serial_out_oe
			&& i2c_addr_sel == {$past(ahi_s), $past(alo_s)})
		else $error("address pins not sampled in two-wire mode");
	irq_set_a: assert property (
		stat_chg |=> !status_change_irq_n ##0 status_change_irq_n_oe)
		else $error("status change did not pull the interrupt low");
	oe_first_a: assert property (
		cur_r.first_map[0] && oe1_n_s |=> !cur_r.en_req[0])
		else $error("first enable pin high left an output enabled");
	lock_out_a: assert property (
		1'b1 |=> loop_b_lock_ok == $past(lock_s[1]))
		else $error("lock output does not follow the loop");
	step_up_a: assert property (
		up_only_s |=> step_pulse == ccp_loop_onehot($past(sel_s))
			&& !step_down)
		else $error("up edge did not step the selected loop");
	step_amt_a: assert property (
		up_only_s and sel_s == CCP_LOOP_A |=> loop_freq_offset[SW-1:0]
			== SW'($past(cur_r.offset[SW-1:0]) + $past(cur_r.step_size)))
		else $error("step size not applied");
	both_ign_a: assert property (
		up_e && dn_e |=> step_pulse == 4'h0)
		else $error("simultaneous steps were not ignored");
	los_off_a: assert property (
		los_s && !cur_r.los_keep |=> cur_r.en_req == '0)
		else $error("reference loss left outputs enabled");
endmodule : ccp_ctrl

// file: ccp_pkg.sv
// Shared constants and types for the clock chip control and status pin block
package ccp_pkg;

	localparam int CCP_NUM_LOOPS = 4;
	localparam int CCP_NUM_OUTS  = 8;
	localparam int CCP_STEP_W    = 16;
	localparam int CCP_SYNC_W    = 16;

	// Loop select encodings
	localparam logic [1:0] CCP_LOOP_A = 2'h0;
	localparam logic [1:0] CCP_LOOP_B = 2'h1;
	localparam logic [1:0] CCP_LOOP_C = 2'h2;
	localparam logic [1:0] CCP_LOOP_D = 2'h3;

	// Level of the interface-select pin that picks the two-wire port
	localparam logic CCP_IF_SEL_I2C = 1'h1;

	// Reset values, per output bit where a field is per output
	localparam logic            CCP_RST_FIRST_MAP  = 1'h1;
	localparam logic            CCP_RST_SECOND_MAP = 1'h0;
	localparam logic            CCP_RST_REG_EN     = 1'h1;
	localparam logic            CCP_RST_SYNC_DIS   = 1'h1;
	localparam logic            CCP_RST_LOS_KEEP   = 1'h0;
	localparam logic            CCP_RST_REF_EXT    = 1'h0;
	localparam logic [15:0]     CCP_RST_STEP       = 16'h0001;

	typedef enum logic [1:0] {
		CCP_DIS_LOW  = 2'h0,
		CCP_DIS_HIGH = 2'h1,
		CCP_DIS_HIZ  = 2'h2
	} ccp_dis_t;

	localparam int CCP_DIS_W = 2;

	typedef enum logic [2:0] {
		CCP_GATE_ON    = 3'h1,
		CCP_GATE_DRAIN = 3'h2,
		CCP_GATE_OFF   = 3'h4
	} ccp_gate_st_t;

	// One-hot decode of the two-bit loop select
	function automatic logic [3:0] ccp_loop_onehot(input logic [1:0] sel);
		ccp_loop_onehot = 4'h1 << sel;
	endfunction : ccp_loop_onehot

endpackage : ccp_pkg

// file: ccp_gate_if.sv
// Link between the control core and one output gate
`timescale 1ns/1ps
interface ccp_gate_if;
	import ccp_pkg::*;
	logic     en_req;
	logic     sync_mode;
	ccp_dis_t dis_state;
	logic     src;
	logic     pin;
	logic     pin_oe;
	modport ctrl (output en_req, output sync_mode, output dis_state,
		output src, input pin, input pin_oe);
	modport gate (input en_req, input sync_mode, input dis_state,
		input src, output pin, output pin_oe);
endinterface : ccp_gate_if

// file: ccp_pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ccp_pin_sync
	import ccp_pkg::*;
#(
	parameter int W = CCP_SYNC_W
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// The first stage feeds only the second one
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : ccp_pin_sync

// file: ccp_out_gate.sv
// Output clock gate with synchronous or immediate disable
`timescale 1ns/1ps
module ccp_out_gate
	import ccp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ccp_gate_if.gate g
);
	typedef struct packed {
		ccp_gate_st_t st;
		logic         pin;
		logic         pin_oe;
	} ccp_gate_state_t;

	ccp_gate_state_t cur_r;
	ccp_gate_state_t cur_nxt;

	always_comb
	begin
		cur_nxt = cur_r;
		unique case (cur_r.st)
			CCP_GATE_ON:
				if (!g.en_req)
					cur_nxt.st = (g.sync_mode && g.src) ? CCP_GATE_DRAIN
						: CCP_GATE_OFF;
			CCP_GATE_DRAIN:
				if (g.en_req)
					cur_nxt.st = CCP_GATE_ON;
				else if (!g.src)
					cur_nxt.st = CCP_GATE_OFF;
			CCP_GATE_OFF:
				// Restart on a low phase in synchronous mode so no runt leaves the pin
				if (g.en_req && (!g.sync_mode || !g.src))
					cur_nxt.st = CCP_GATE_ON;
			default:
				cur_nxt.st = CCP_GATE_OFF;
		endcase
		if (cur_nxt.st != CCP_GATE_OFF)
		begin
			cur_nxt.pin    = g.src;
			cur_nxt.pin_oe = 1'b1;
		end
		else
		begin
			cur_nxt.pin    = (g.dis_state == CCP_DIS_HIGH);
			cur_nxt.pin_oe = (g.dis_state != CCP_DIS_HIZ);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_r.st     <= CCP_GATE_OFF;
			cur_r.pin    <= 1'b0;
			cur_r.pin_oe <= 1'b1;
		end
		else
			cur_r <= cur_nxt;
	end

	assign g.pin    = cur_r.pin;
	assign g.pin_oe = cur_r.pin_oe;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence drain_done_s;
		cur_r.st == CCP_GATE_DRAIN && !g.en_req && !g.src;
	endsequence

	async_stop_a: assert property (
		cur_r.st == CCP_GATE_ON && !g.en_req && !g.sync_mode
		|=> cur_r.st == CCP_GATE_OFF)
		else $error("immediate disable did not stop the output");
	sync_hold_a: assert property (
		cur_r.st == CCP_GATE_ON && !g.en_req && g.sync_mode && g.src
		|=> cur_r.st == CCP_GATE_DRAIN ##0 cur_r.pin)
		else $error("synchronous disable cut a high phase");
	drain_end_a: assert property (
		drain_done_s |=> cur_r.st == CCP_GATE_OFF)
		else $error("output did not stop after its period ended");
	off_hiz_a: assert property (
		cur_r.st == CCP_GATE_OFF && $past(g.dis_state) == CCP_DIS_HIZ
		|-> !cur_r.pin_oe)
		else $error("disabled output not released to high impedance");
endmodule : ccp_out_gate

// file: ccp_far_model.sv
// Far-side model: host serial clock and raw output clock sources
`timescale 1ns/1ps
module ccp_far_model
	import ccp_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    frame_en,
	output logic                         sclk,
	output logic [CCP_NUM_OUTS-1:0]      out_src
);
	logic [1:0] div_r;

	// Host clock stands low outside frames; offset so it never meets clk
	initial
	begin
		sclk = 1'h0;
		#7;
		forever
		begin
			#100;
			sclk = frame_en ? ~sclk : 1'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= 2'h0;
		else
			div_r <= div_r + 2'h1;
	end
	assign out_src = {CCP_NUM_OUTS{div_r[1]}};
endmodule : ccp_far_model

// file: ccp_ctrl_tb_top.sv
// Self-checking testbench of the control and status pin block
`timescale 1ns/1ps
module ccp_ctrl_tb_top
	import ccp_pkg::*;
;
	logic clk, rst_n, host_if_sel, spi_four_wire, sdio_in, sdio_out, sdio_oe;
	logic addr_high_or_serial_out_in, addr_high_or_serial_out_out;
	logic addr_high_or_serial_out_oe, addr_low_or_chip_select_n, sclk;
	logic i2c_sda_low, spi_tx_bit, spi_tx_en, port_is_i2c, port_is_spi4;
	logic spi_selected, serial_data_in, serial_clk_rise, status_irq_clear;
	logic status_change_irq_n, status_change_irq_n_oe, ref_loss_raw;
	logic loop_a_lock_ok, loop_b_lock_ok, loop_c_lock_ok, loop_d_lock_ok;
	logic ref_signal_lost, ref_ext_mode, cfg_load, cfg_los_keep, cfg_ref_ext;
	logic out_enable_pin_first_n, out_enable_pin_second_n, step_down;
	logic loop_select_bit0, loop_select_bit1, freq_step_up, freq_step_down;
	logic host_sdio, host_a1, frame_en;
	logic [1:0]  i2c_addr_sel;
	logic [3:0]  loop_lock_raw, step_pulse;
	logic [7:0]  cfg_first_map, cfg_second_map, cfg_reg_en, cfg_sync_dis;
	logic [7:0]  out_src, out_clk, out_clk_oe;
	logic [15:0] cfg_step_size, cfg_dis_state;
	logic [63:0] loop_freq_offset;
	int          mismatches, checks_done;

	// Wire level of the shared pins from the chip's enable; the host drives them otherwise
	assign sdio_in = sdio_oe ? sdio_out : host_sdio;
	assign addr_high_or_serial_out_in =
		addr_high_or_serial_out_oe ? addr_high_or_serial_out_out : host_a1;

	ccp_ctrl #(.N(8), .SW(16)) uut (.clk, .rst_n, .host_if_sel, .spi_four_wire,
		.sdio_in, .sdio_out, .sdio_oe, .addr_high_or_serial_out_in,
		.addr_high_or_serial_out_out, .addr_high_or_serial_out_oe,
		.addr_low_or_chip_select_n, .sclk, .i2c_sda_low, .spi_tx_bit,
		.spi_tx_en, .port_is_i2c, .port_is_spi4, .i2c_addr_sel, .spi_selected,
		.serial_data_in, .serial_clk_rise, .status_irq_clear,
		.status_change_irq_n, .status_change_irq_n_oe, .loop_lock_raw,
		.ref_loss_raw, .loop_a_lock_ok, .loop_b_lock_ok, .loop_c_lock_ok,
		.loop_d_lock_ok, .ref_signal_lost, .ref_ext_mode,
		.out_enable_pin_first_n, .out_enable_pin_second_n, .cfg_load,
		.cfg_first_map, .cfg_second_map, .cfg_reg_en, .cfg_sync_dis,
		.cfg_dis_state, .cfg_los_keep, .cfg_ref_ext, .cfg_step_size,
		.loop_select_bit0, .loop_select_bit1, .freq_step_up, .freq_step_down,
		.step_pulse, .step_down, .loop_freq_offset, .out_src, .out_clk,
		.out_clk_oe);

	ccp_far_model far (.clk, .rst_n, .frame_en, .sclk, .out_src);

	initial clk = 1'h0;
	always #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : wait_clk

	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask : chk

	task automatic load_cfg;
		cfg_load = 1'h1;
		wait_clk(1);
		cfg_load = 1'h0;
		wait_clk(8);
	endtask : load_cfg

	// Hold the step pins long enough to be seen, collecting any pulse
	task automatic step_pins(input logic up, input logic dn,
		output logic [3:0] seen);
		seen = 4'h0;
		freq_step_up = up;
		freq_step_down = dn;
		repeat (8)
		begin
			wait_clk(1);
			seen = seen | step_pulse;
		end
		freq_step_up = 1'h0;
		freq_step_down = 1'h0;
		wait_clk(4);
	endtask : step_pins

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// A hang counts as a mismatch and still ends in the one report
	initial
	begin
		#2000000;
		mismatches++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [3:0]  seen;
		logic [15:0] eo [4];
		int          rises;
		rst_n = 1'h0; host_if_sel = 1'h1; spi_four_wire = 1'h0;
		addr_low_or_chip_select_n = 1'h1; i2c_sda_low = 1'h0;
		spi_tx_bit = 1'h0; spi_tx_en = 1'h0; status_irq_clear = 1'h0;
		loop_lock_raw = 4'hF; ref_loss_raw = 1'h0; cfg_load = 1'h0;
		out_enable_pin_first_n = 1'h0; out_enable_pin_second_n = 1'h1;
		cfg_first_map = 8'hFF; cfg_second_map = 8'h00; cfg_reg_en = 8'hFF;
		cfg_sync_dis = 8'hFF; cfg_dis_state = {8{CCP_DIS_HIZ}};
		cfg_los_keep = 1'h0; cfg_ref_ext = 1'h0; cfg_step_size = 16'h0001;
		loop_select_bit0 = 1'h0; loop_select_bit1 = 1'h0;
		freq_step_up = 1'h0; freq_step_down = 1'h0; host_sdio = 1'h1;
		host_a1 = 1'h0; frame_en = 1'h0;
		mismatches = 0; checks_done = 0;
		foreach (eo[i]) eo[i] = 16'h0000;
		wait_clk(16);
		chk(out_clk_oe, 8'hFF, "outputs driven in reset");
		chk(out_clk, 8'h00, "outputs held low in reset");
		rst_n = 1'h1;
		wait_clk(6);
		chk(loop_freq_offset, 64'h0, "offsets after reset");
		chk(ref_ext_mode, 1'h0, "crystal after reset");
		$display("test reset done");

		host_a1 = 1'h1;
		addr_low_or_chip_select_n = 1'h0;
		i2c_sda_low = 1'h1;
		wait_clk(5);
		chk(port_is_i2c, 1'h1, "two-wire mode");
		chk(i2c_addr_sel, 2'h2, "address pins");
		chk({sdio_oe, sdio_out, serial_data_in}, 3'h4,
			"sda pulled low");
		i2c_sda_low = 1'h0;
		host_if_sel = 1'h0;
		spi_four_wire = 1'h1;
		spi_tx_en = 1'h1;
		spi_tx_bit = 1'h1;
		wait_clk(5);
		chk(port_is_spi4, 1'h1, "four-wire mode");
		chk(spi_selected, 1'h1, "chip selected");
		chk(i2c_addr_sel, 2'h0, "no address in spi");
		chk({addr_high_or_serial_out_oe, addr_high_or_serial_out_out,
			sdio_oe}, 3'h6, "four-wire drive");
		addr_low_or_chip_select_n = 1'h1;
		wait_clk(5);
		chk({spi_selected, addr_high_or_serial_out_oe}, 2'h0,
			"deselected");
		addr_low_or_chip_select_n = 1'h0;
		spi_four_wire = 1'h0;
		wait_clk(5);
		chk({sdio_oe, addr_high_or_serial_out_oe, sdio_out, serial_data_in},
			4'hB, "three-wire");
		spi_tx_en = 1'h0;
		rises = 0;
		frame_en = 1'h1;
		for (int c = 0; c < 72; c++)
		begin
			if (c == 64)
				frame_en = 1'h0;
			wait_clk(1);
			if (serial_clk_rise === 1'h1)
				rises++;
		end
		chk(rises, 8, "serial clock rises in frame");
		$display("test host port done");

		status_irq_clear = 1'h1;
		wait_clk(3);
		status_irq_clear = 1'h0;
		wait_clk(2);
		chk(status_change_irq_n, 1'h1, "irq idle");
		loop_lock_raw = 4'hD;
		wait_clk(5);
		chk({loop_d_lock_ok, loop_c_lock_ok, loop_b_lock_ok, loop_a_lock_ok},
			4'hD, "lock outputs");
		chk({status_change_irq_n, status_change_irq_n_oe}, 2'h1,
			"irq on lock loss");
		status_irq_clear = 1'h1;
		wait_clk(3);
		status_irq_clear = 1'h0;
		chk(status_change_irq_n, 1'h1, "irq cleared");
		loop_lock_raw = 4'hF;
		$display("test status done");

		for (int s = 0; s < 4; s++)
		begin
			{loop_select_bit1, loop_select_bit0} = s[1:0];
			step_pins(1'h1, 1'h0, seen);
			eo[s] = eo[s] + 16'h0001;
			chk(seen, 64'h1 << s, "step pulse of loop");
			chk(loop_freq_offset, {eo[3], eo[2], eo[1], eo[0]},
				"offset up");
		end
		cfg_step_size = 16'h0100;
		load_cfg();
		step_pins(1'h0, 1'h1, seen);
		eo[3] = eo[3] - 16'h0100;
		chk({seen, step_down}, 5'h11, "step down loop d");
		chk(loop_freq_offset, {eo[3], eo[2], eo[1], eo[0]},
			"programmed step");
		{loop_select_bit1, loop_select_bit0} = 2'h2;
		step_pins(1'h1, 1'h1, seen);
		chk(seen, 4'h0, "both pins at once");
		chk(loop_freq_offset, {eo[3], eo[2], eo[1], eo[0]},
			"offset unchanged");
		$display("test steps done");

		chk(out_clk_oe, 8'hFF, "first pin low enables all");
		out_enable_pin_first_n = 1'h1;
		wait_clk(8);
		chk(out_clk_oe, 8'h00, "first pin high disables all");
		cfg_first_map = 8'h0F;
		cfg_second_map = 8'hF0;
		out_enable_pin_first_n = 1'h0;
		load_cfg();
		chk(out_clk_oe, 8'h0F, "second pin mapped");
		out_enable_pin_second_n = 1'h0;
		cfg_reg_en = 8'hFE;
		load_cfg();
		chk(out_clk_oe, 8'hFE, "register disable");
		ref_loss_raw = 1'h1;
		wait_clk(8);
		chk({ref_signal_lost, out_clk_oe}, 9'h100, "reference lost");
		cfg_los_keep = 1'h1;
		load_cfg();
		chk(out_clk_oe, 8'hFE, "kept running");
		ref_loss_raw = 1'h0;
		cfg_los_keep = 1'h0;
		cfg_reg_en = 8'hFF;
		cfg_first_map = 8'hFF;
		cfg_second_map = 8'h00;
		cfg_dis_state[1:0] = CCP_DIS_HIGH;
		cfg_sync_dis = 8'h00;
		cfg_ref_ext = 1'h1;
		out_enable_pin_first_n = 1'h1;
		load_cfg();
		chk({out_clk[0], out_clk_oe}, 9'h101, "disabled high");
		chk(ref_ext_mode, 1'h1, "external reference");
		$display("test output enable done");

		// Reset in mid-run must drop every setting back to its default
		rst_n = 1'h0;
		wait_clk(2);
		chk({out_clk, out_clk_oe}, 16'h00FF, "outputs low in reset");
		rst_n = 1'h1;
		wait_clk(6);
		chk({out_clk, out_clk_oe}, 16'h00FF, "default disable low");
		chk(loop_freq_offset, 64'h0, "offsets after mid reset");
		chk(ref_ext_mode, 1'h0, "crystal after mid reset");
		$display("test mid reset done");
		final_report();
	end
endmodule : ccp_ctrl_tb_top
